//--- pkg/dacc_defines.svh
`ifndef DACC_DEFINES_SVH
`define DACC_DEFINES_SVH

// ****************************************************************
// Timing figures
// ****************************************************************
`define DACC_ACLK_PERIOD_PS 40000
`define DACC_STROBE_DLY_PS 5800
`define DACC_PD_DLY_PS 10000
// Least time rounds up, never below one cycle
`define DACC_CEIL_CYC(ps) ((((ps) + `DACC_ACLK_PERIOD_PS - 1) / `DACC_ACLK_PERIOD_PS) < 1 ? 1 : \
	(((ps) + `DACC_ACLK_PERIOD_PS - 1) / `DACC_ACLK_PERIOD_PS))
`define DACC_STROBE_DLY_CYC `DACC_CEIL_CYC(`DACC_STROBE_DLY_PS)
`define DACC_PD_DLY_CYC `DACC_CEIL_CYC(`DACC_PD_DLY_PS)
`define DACC_DLL_LOCK_EDGES 100
`define DACC_PERIOD_TOL 1
`define DACC_LATENCY 8

// ****************************************************************
// Output coding
// ****************************************************************
`define DACC_MID_CODE 12'h800
`define DACC_POS_FULL 12'h7FF
`define DACC_NEG_FULL 12'h800

// ****************************************************************
// Register map and fields
// ****************************************************************
`define DACC_REG_CTRL 4'h0
`define DACC_REG_STATUS 4'h4
`define DACC_REG_PERIOD 4'h8
`define DACC_REG_SAMPLES 4'hC
`define DACC_CTRL_SOFT_PD 0
`define DACC_CTRL_RELOCK 1
`define DACC_CTRL_RESET 1'h0
`define DACC_RESP_OKAY 2'h0
`define DACC_RESP_SLVERR 2'h2

`endif

//--- pkg/dacc_pkg.sv
package dacc_pkg;

	// ****************************************************************
	// Types
	// ****************************************************************
	// Strobe phases, Gray coded along high -> delay -> low
	typedef enum logic [1:0] {
		DACC_STR_HIGH = 2'h0,
		DACC_STR_DELAY = 2'h1,
		DACC_STR_LOW = 2'h3
	} dacc_strobe_t;

	// Decoded {quarter, half} rate select
	typedef enum logic [1:0] {
		DACC_RATE_FULL = 2'h0,
		DACC_RATE_HALF = 2'h1,
		DACC_RATE_QUARTER = 2'h2,
		DACC_RATE_ILLEGAL = 2'h3
	} dacc_rate_t;

endpackage : dacc_pkg

//--- hdl/dacc_top.sv
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ns
`include "dacc_defines.svh"

// What this block does
// (R01) Relock after clock change: about 100 edges
// (R02) Strobe timing independent of input duty cycle
// (R03) Select single-ended or differential clock input
// (R04) Clock input pins float while powered down
// (R05) Sample on falling edge of positive clock
// (R06) Rate pins: full, half, quarter; 11 forbidden
// (R07) Output word appears eight clocks after sampling
// (R08) Strobe follows clock; data changes at fall
// (R09) Strobe fall trails clock fall fixed delay
// (R10) Strobe floats and returns around power-down
// (R11) Back end latches on strobe rising edge
// (R12) Over-range flag high outside full scale
// (R13) Flag moves with data, same latency
// (R14) Flags float during power-down
// (R15) Two independent 12-bit tri-state buses
// (R16) Format pin picks Gray or two's complement
// (R17) Gray mode offset: zero input is 2048
// (R18) Two's complement: zero input gives zero
// (R19) Gray is reflected code of offset binary
// (R20) Out of range saturates at full scale
module dacc_top #(
	parameter int AIN_W = 14,
	parameter int DATA_W = 12,
	parameter int PERIOD_W = 16
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Converter clock and control pins
	input wire logic clock_in_pos,
	input wire logic clock_in_neg,
	input wire logic clock_type_select,
	input wire logic half_rate_select,
	input wire logic quarter_rate_select,
	input wire logic code_format_select,
	input wire logic power_down_pin,
	output logic clock_in_hiz,
	// Quantised analog stand-ins, signed, wider than the output word
	input wire logic [AIN_W-1:0] analog_in_a,
	input wire logic [AIN_W-1:0] analog_in_b,
	// Output pins with enables, and the lock flag without one
	output logic [DATA_W-1:0] channel_a_bus,
	output logic channel_a_bus_oe,
	output logic [DATA_W-1:0] channel_b_bus,
	output logic channel_b_bus_oe,
	output logic over_range_flag_a,
	output logic over_range_flag_a_oe,
	output logic over_range_flag_b,
	output logic over_range_flag_b_oe,
	output logic output_valid_strobe,
	output logic output_valid_strobe_oe,
	output logic duty_equalizer_locked,
	// AXI4-Lite write channels
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	localparam int NSYNC = 7;
	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] pin_s1_q;
	logic [NSYNC-1:0] pin_s2_q;
	logic [AIN_W-1:0] ain_s1_q [2];
	logic [AIN_W-1:0] ain_s2_q [2];

	assign pin_raw = {power_down_pin, code_format_select, quarter_rate_select,
		half_rate_select, clock_type_select, clock_in_neg, clock_in_pos};

	// Two flip-flops on every outside level; analog words move slowly
	always_ff @(posedge aclk) begin
		pin_s1_q <= pin_raw;
		pin_s2_q <= pin_s1_q;
		ain_s1_q[0] <= analog_in_a;
		ain_s1_q[1] <= analog_in_b;
		ain_s2_q <= ain_s1_q;
	end

	wire pos_s = pin_s2_q[0];
	wire neg_s = pin_s2_q[1];
	wire diff_sel_s = pin_s2_q[2];
	wire half_s = pin_s2_q[3];
	wire quarter_s = pin_s2_q[4];
	wire gray_sel_s = pin_s2_q[5];
	wire pd_pin_s = pin_s2_q[6];

	// ****************************************************************
	// Conversion clock and sampling edge
	// ****************************************************************
	logic conv_prev_q;
	wire conv_lvl = diff_sel_s ? (pos_s & ~neg_s) : pos_s; // [R03]
	wire fall_evt = conv_prev_q & ~conv_lvl; // [R05]

	// Previous conversion-clock level
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			conv_prev_q <= 1'h0;
		end else begin
			conv_prev_q <= conv_lvl;
		end
	end

	// ****************************************************************
	// Clock divider
	// ****************************************************************
	logic [1:0] div_q;
	dacc_pkg::dacc_rate_t rate;
	logic sample_evt;

	assign rate = dacc_pkg::dacc_rate_t'({quarter_s, half_s});

	// Pick which falling edges sample
	always_comb begin
		unique case (rate)
			dacc_pkg::DACC_RATE_HALF: sample_evt = fall_evt & (div_q[0] == 1'h0); // [R06]
			dacc_pkg::DACC_RATE_QUARTER: sample_evt = fall_evt & (div_q == 2'h0); // [R06]
			default: sample_evt = fall_evt; // Forbidden 11 falls back to full rate
		endcase
	end

	// Edge counter for the divider
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_q <= 2'h0;
		end else if (fall_evt) begin
			div_q <= div_q + 2'h1;
		end
	end

	// ****************************************************************
	// Period measurement and lock
	// ****************************************************************
	logic [PERIOD_W-1:0] cnt_q;
	logic [PERIOD_W-1:0] period_q;
	logic [6:0] lock_cnt_q;
	logic relock_q;
	wire [PERIOD_W-1:0] per_diff = (cnt_q > period_q) ? cnt_q - period_q : period_q - cnt_q;
	wire freq_change = fall_evt & (per_diff > PERIOD_W'(`DACC_PERIOD_TOL));
	wire locked = lock_cnt_q == 7'(`DACC_DLL_LOCK_EDGES);

	// Measure clock period in aclk cycles
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= '0;
			period_q <= '0;
		end else if (fall_evt) begin
			cnt_q <= PERIOD_W'(1);
			period_q <= cnt_q;
		end else if (cnt_q != '1) begin
			cnt_q <= cnt_q + PERIOD_W'(1);
		end
	end

	// Count stable edges until lock
	always_ff @(posedge aclk) begin
		if (!aresetn || freq_change || relock_q) begin
			lock_cnt_q <= 7'h0; // [R01]
		end else if (fall_evt && !locked) begin
			lock_cnt_q <= lock_cnt_q + 7'h1; // [R01]
		end
	end

	// ****************************************************************
	// Quantiser and conversion pipeline
	// ****************************************************************
	logic [DATA_W-1:0] pipe_data_q [2][`DACC_LATENCY + 1]; // Last stage: eight falls on
	logic pipe_ovr_q [2][`DACC_LATENCY + 1];
	logic [DATA_W-1:0] sat_data [2];
	logic sat_ovr [2];

	// Clamp the stand-in to the signed output range
	generate
		for (genvar c = 0; c < 2; c++) begin : g_quant
			wire signed [AIN_W-1:0] v = ain_s2_q[c];
			wire hi = v > $signed(AIN_W'(`DACC_POS_FULL)); // [R12]
			wire lo = v < -$signed(AIN_W'(`DACC_MID_CODE)); // [R12]
			assign sat_ovr[c] = hi | lo; // [R12]
			assign sat_data[c] = hi ? `DACC_POS_FULL : lo ? `DACC_NEG_FULL : v[DATA_W-1:0]; // [R20]
		end
	endgenerate

	// Advance one stage per input clock; load only on sampling edges
	always_ff @(posedge aclk) begin
		if (fall_evt) begin
			for (int c = 0; c < 2; c++) begin
				pipe_data_q[c][0] <= sample_evt ? sat_data[c] : pipe_data_q[c][0]; // [R07]
				pipe_ovr_q[c][0] <= sample_evt ? sat_ovr[c] : pipe_ovr_q[c][0]; // [R13]
				for (int s = 1; s <= `DACC_LATENCY; s++) begin
					pipe_data_q[c][s] <= pipe_data_q[c][s-1]; // [R07]
					pipe_ovr_q[c][s] <= pipe_ovr_q[c][s-1]; // [R13]
				end
			end
		end
	end

	// ****************************************************************
	// Output coding
	// ****************************************************************
	logic [DATA_W-1:0] coded [2];

	// Two's complement as is, Gray from offset binary
	generate
		for (genvar c = 0; c < 2; c++) begin : g_code
			wire [DATA_W-1:0] tc = pipe_data_q[c][`DACC_LATENCY]; // [R18]
			wire [DATA_W-1:0] ob = tc ^ `DACC_MID_CODE; // [R17]
			wire [DATA_W-1:0] gr = ob ^ (ob >> 1); // [R19]
			assign coded[c] = gray_sel_s ? gr : tc; // [R16]
		end
	endgenerate

	// ****************************************************************
	// Duty-corrected strobe
	// ****************************************************************
	dacc_pkg::dacc_strobe_t str_q;
	logic [PERIOD_W-1:0] str_cnt_q;
	logic [DATA_W-1:0] out_a_q;
	logic [DATA_W-1:0] out_b_q;
	logic ovr_a_q;
	logic ovr_b_q;
	logic [31:0] samples_q;
	wire [PERIOD_W-1:0] half_period = (period_q >> 1) == '0 ? PERIOD_W'(1) : period_q >> 1;
	wire str_load = (str_q == dacc_pkg::DACC_STR_DELAY) &&
		(str_cnt_q == PERIOD_W'(`DACC_STROBE_DLY_CYC - 1));

	// Low phase timed from the measured period, not the input duty
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			str_q <= dacc_pkg::DACC_STR_HIGH;
			str_cnt_q <= '0;
		end else if (fall_evt) begin
			str_q <= dacc_pkg::DACC_STR_DELAY; // [R09]
			str_cnt_q <= '0;
		end else begin
			unique case (str_q)
				dacc_pkg::DACC_STR_HIGH: str_cnt_q <= '0;
				dacc_pkg::DACC_STR_DELAY: begin
					str_cnt_q <= str_load ? '0 : str_cnt_q + PERIOD_W'(1); // [R09]
					str_q <= str_load ? dacc_pkg::DACC_STR_LOW : str_q;
				end
				dacc_pkg::DACC_STR_LOW: begin
					str_cnt_q <= str_cnt_q + PERIOD_W'(1);
					if (str_cnt_q >= half_period - PERIOD_W'(1)) begin
						str_q <= dacc_pkg::DACC_STR_HIGH; // [R02]
					end
				end
				default: str_q <= dacc_pkg::DACC_STR_HIGH;
			endcase
		end
	end

	// Data and flags change only as the strobe falls
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_a_q <= '0;
			out_b_q <= '0;
			ovr_a_q <= 1'h0;
			ovr_b_q <= 1'h0;
		end else if (str_load) begin
			out_a_q <= coded[0]; // [R15] [R08]
			out_b_q <= coded[1]; // [R15]
			ovr_a_q <= pipe_ovr_q[0][`DACC_LATENCY]; // [R13]
			ovr_b_q <= pipe_ovr_q[1][`DACC_LATENCY]; // [R13]
		end
	end

	// Sample counter for status
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			samples_q <= 32'h0;
		end else if (sample_evt) begin
			samples_q <= samples_q + 32'h1;
		end
	end

	// ****************************************************************
	// Power-down and output enables
	// ****************************************************************
	logic ctrl_pd_q;
	localparam int PD_DLY = `DACC_PD_DLY_CYC;
	logic [`DACC_PD_DLY_CYC-1:0] pd_dly_q;
	wire pd_eff = pd_pin_s | ctrl_pd_q;

	// Enables follow power-down after the fixed delay
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pd_dly_q <= '1;
		end else begin
			pd_dly_q <= PD_DLY'({pd_dly_q, pd_eff}); // [R10] [R14]
		end
	end

	wire out_en = ~pd_dly_q[`DACC_PD_DLY_CYC-1];
	assign clock_in_hiz = pd_eff; // [R04]
	assign channel_a_bus = out_a_q;
	assign channel_b_bus = out_b_q;
	assign over_range_flag_a = ovr_a_q;
	assign over_range_flag_b = ovr_b_q;
	assign output_valid_strobe = (str_q == dacc_pkg::DACC_STR_HIGH) ||
		(str_q == dacc_pkg::DACC_STR_DELAY); // [R08]
	assign channel_a_bus_oe = out_en; // [R15]
	assign channel_b_bus_oe = out_en; // [R15]
	assign over_range_flag_a_oe = out_en; // [R14]
	assign over_range_flag_b_oe = out_en; // [R14]
	assign output_valid_strobe_oe = out_en; // [R10]
	assign duty_equalizer_locked = locked;

	// ****************************************************************
	// AXI4-Lite slave
	// ****************************************************************
	logic aw_hold_q;
	logic w_hold_q;
	logic [3:0] awaddr_q;
	logic [31:0] wdata_q;
	logic wstrb0_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
	assign s_axi_wready = ~w_hold_q & ~bvalid_q;
	assign s_axi_arready = ~rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	wire wr_go = aw_hold_q & w_hold_q & ~bvalid_q;
	wire wr_ctrl = awaddr_q == `DACC_REG_CTRL;
	wire wr_known = wr_ctrl | (awaddr_q == `DACC_REG_STATUS) |
		(awaddr_q == `DACC_REG_PERIOD) | (awaddr_q == `DACC_REG_SAMPLES);
	wire rd_go = s_axi_arvalid & ~rvalid_q;
	wire [31:0] status_word = {26'h0, rate == dacc_pkg::DACC_RATE_ILLEGAL, gray_sel_s,
		rate, pd_eff, locked};

	// Write address and data, taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'h0;
			w_hold_q <= 1'h0;
			awaddr_q <= 4'h0;
			wdata_q <= 32'h0;
			wstrb0_q <= 1'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'h1;
				awaddr_q <= {s_axi_awaddr[3:2], 2'h0};
			end else if (wr_go) begin
				aw_hold_q <= 1'h0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'h1;
				wdata_q <= s_axi_wdata;
				wstrb0_q <= s_axi_wstrb[0];
			end else if (wr_go) begin
				w_hold_q <= 1'h0;
			end
		end
	end

	// Commit write and answer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'h0;
			bresp_q <= `DACC_RESP_OKAY;
			ctrl_pd_q <= `DACC_CTRL_RESET;
			relock_q <= 1'h0;
		end else begin
			relock_q <= wr_go & wr_ctrl & wstrb0_q & wdata_q[`DACC_CTRL_RELOCK];
			if (wr_go && wr_ctrl && wstrb0_q) begin
				ctrl_pd_q <= wdata_q[`DACC_CTRL_SOFT_PD];
			end
			if (wr_go) begin
				bvalid_q <= 1'h1;
				bresp_q <= wr_known ? `DACC_RESP_OKAY : `DACC_RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'h0;
			end
		end
	end

	// Read decode and answer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'h0;
			rdata_q <= 32'h0;
			rresp_q <= `DACC_RESP_OKAY;
		end else if (rd_go) begin
			rvalid_q <= 1'h1;
			rresp_q <= `DACC_RESP_OKAY;
			unique case ({s_axi_araddr[3:2], 2'h0})
				`DACC_REG_CTRL: rdata_q <= {31'h0, ctrl_pd_q};
				`DACC_REG_STATUS: rdata_q <= status_word;
				`DACC_REG_PERIOD: rdata_q <= 32'(period_q);
				`DACC_REG_SAMPLES: rdata_q <= samples_q;
				default: begin
					rdata_q <= 32'h0;
					rresp_q <= `DACC_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_q <= 1'h0;
		end
	end

endmodule : dacc_top

//--- dv/dacc_properties.sv
`timescale 1ns/1ns
// ********
// Checker on the converter pins
// ********
module dacc_properties #(
	parameter int DATA_W = 12
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Pins in
	input wire logic clock_in_pos,
	input wire logic power_down_pin,
	// Pins out
	input wire logic clock_in_hiz,
	input wire logic duty_equalizer_locked,
	input wire logic [DATA_W-1:0] channel_a_bus,
	input wire logic channel_a_bus_oe,
	input wire logic [DATA_W-1:0] channel_b_bus,
	input wire logic channel_b_bus_oe,
	input wire logic over_range_flag_a,
	input wire logic over_range_flag_a_oe,
	input wire logic over_range_flag_b,
	input wire logic over_range_flag_b_oe,
	input wire logic output_valid_strobe,
	input wire logic output_valid_strobe_oe
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Count converter clock falls since reset, saturating
	logic [7:0] falls_q;
	logic pos_q;
	always_ff @(posedge aclk) begin
		pos_q <= clock_in_pos;
		if (!aresetn) falls_q <= 8'h00;
		else if (pos_q && !clock_in_pos && falls_q != 8'hFF) falls_q <= falls_q + 8'h01;
	end
	// All enables, all of them or any of them
	wire oe_all = channel_a_bus_oe & channel_b_bus_oe & over_range_flag_a_oe &
		over_range_flag_b_oe & output_valid_strobe_oe;
	wire oe_any = channel_a_bus_oe | channel_b_bus_oe | over_range_flag_a_oe |
		over_range_flag_b_oe | output_valid_strobe_oe;
	a_oe_together: assert property (oe_all == oe_any)
		else $error("enables differ");
	a_pd_floats: assert property (power_down_pin [*4] |-> !oe_any)
		else $error("outputs driven in power-down");
	a_clk_pins_float: assert property ($rose(clock_in_hiz) |=> !oe_any)
		else $error("clock pins float but outputs driven");
	a_strobe_trails: assert property ($fell(clock_in_pos) && oe_all && !power_down_pin
		|-> ##[2:6] $fell(output_valid_strobe))
		else $error("strobe fall missing");
	a_a_at_fall: assert property ($changed(channel_a_bus) |-> $fell(output_valid_strobe))
		else $error("bus a moved off strobe fall");
	a_b_at_fall: assert property ($changed(channel_b_bus) |-> $fell(output_valid_strobe))
		else $error("bus b moved off strobe fall");
	a_flags_at_fall: assert property ($changed({over_range_flag_a, over_range_flag_b})
		|-> $fell(output_valid_strobe))
		else $error("flag moved off strobe fall");
	a_rise_stable: assert property ($rose(output_valid_strobe)
		|-> $stable(channel_a_bus) && $stable(over_range_flag_a))
		else $error("data moved at strobe rise");
	a_sat_codes: assert property (over_range_flag_a
		|-> channel_a_bus inside {12'h7FF, 12'h800, 12'h000})
		else $error("over range word not saturated");
	a_lock_count: assert property (duty_equalizer_locked |-> falls_q >= 8'h64)
		else $error("locked too soon");
	c_lock: cover property ($rose(duty_equalizer_locked));
	c_pd: cover property ($fell(oe_any));
	c_over: cover property (over_range_flag_a && over_range_flag_b_oe);
endmodule : dacc_properties

bind dacc_top dacc_properties #(.DATA_W(DATA_W)) dacc_properties_i (.*);

//--- dv/dacc_backend.sv
`timescale 1ns/1ns
// ********
// Back end latching converter words
// ********
module dacc_backend (
	// Strobe
	input wire logic output_valid_strobe,
	input wire logic output_valid_strobe_oe,
	// Data and flags with enables
	input wire logic [11:0] channel_a_bus,
	input wire logic channel_a_bus_oe,
	input wire logic [11:0] channel_b_bus,
	input wire logic channel_b_bus_oe,
	input wire logic [1:0] flags,
	input wire logic [1:0] flags_oe,
	// Latched word
	output logic [11:0] cap_a,
	output logic [11:0] cap_b,
	output logic [1:0] cap_or
);
	// Undriven lines read back the inverse of the last word
	wire [11:0] a_w = channel_a_bus_oe ? channel_a_bus : ~cap_a;
	wire [11:0] b_w = channel_b_bus_oe ? channel_b_bus : ~cap_b;
	wire [1:0] f_w = (flags & flags_oe) | (~cap_or & ~flags_oe);
	// Capture on the strobe rising edge while it is driven
	always @(posedge output_valid_strobe) begin
		if (output_valid_strobe_oe) begin
			cap_a <= a_w;
			cap_b <= b_w;
			cap_or <= f_w;
		end
	end
endmodule : dacc_backend

//--- dv/dacc_tb_top.sv
`timescale 1ns/1ns
// ********
// Bench
// ********
module dacc_tb_top;
	logic aclk = 1'b0, aresetn = 1'b0, lk = 1'b1, power_down_pin = 1'b0;
	logic clock_type_select = 1'b0, half_rate_select = 1'b0, quarter_rate_select = 1'b0;
	logic code_format_select = 1'b0;
	logic [13:0] analog_in_a = 14'h0000, analog_in_b = 14'h0000;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [11:0] channel_a_bus, channel_b_bus, cap_a, cap_b;
	logic [1:0] cap_or;
	logic clock_in_hiz, channel_a_bus_oe, channel_b_bus_oe, over_range_flag_a;
	logic over_range_flag_a_oe, over_range_flag_b, over_range_flag_b_oe;
	logic output_valid_strobe, output_valid_strobe_oe, duty_equalizer_locked;
	wire clock_in_pos = lk;
	wire clock_in_neg = clock_type_select & ~lk;
	wire [4:0] oes = {channel_a_bus_oe, channel_b_bus_oe, over_range_flag_a_oe,
		over_range_flag_b_oe, output_valid_strobe_oe};
	int hi = 160;
	int bad_count = 0;
	int total_checks = 0;
	dacc_top dacc_top_i (.*);
	dacc_backend dacc_backend_i (
		.output_valid_strobe(output_valid_strobe),
		.output_valid_strobe_oe(output_valid_strobe_oe),
		.channel_a_bus(channel_a_bus),
		.channel_a_bus_oe(channel_a_bus_oe),
		.channel_b_bus(channel_b_bus),
		.channel_b_bus_oe(channel_b_bus_oe),
		.flags({over_range_flag_b, over_range_flag_a}),
		.flags_oe({over_range_flag_b_oe, over_range_flag_a_oe}),
		.cap_a(cap_a),
		.cap_b(cap_b),
		.cap_or(cap_or)
	);
	// System clock and a 320 ns converter clock with adjustable high time
	always #20 aclk = ~aclk;
	always begin
		#(hi) lk = 1'b0;
		#(320 - hi) lk = 1'b1;
	end
	task chk(input bit ok, input string m);
		total_checks++;
		if (!ok) begin
			bad_count++;
			$display("BAD %0t %s", $time, m);
		end
	endtask : chk
	task report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop
	// Wait for n strobe falls, seen at the falling clock edge
	task sfall(input int n);
		int t;
		logic p;
		repeat (n) begin
			t = 0;
			p = 1'b0;
			while (!(p === 1'b1 && output_valid_strobe === 1'b0) && t < 100) begin
				p = output_valid_strobe;
				@(negedge aclk);
				t++;
			end
			chk(t < 100, "no strobe");
		end
	endtask : sfall
	// Waits for the answer however long; only the watchdog ends a hang
	task axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		bit ta, tw, tb;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		tb = 0;
		while (!tb) begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready === 1'b1;
			tw = s_axi_wvalid && s_axi_wready === 1'b1;
			tb = s_axi_bvalid === 1'b1;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		chk(tb, "write hang");
	endtask : axi_wr
	task axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		bit ta, tr;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		tr = 0;
		while (!tr) begin
			@(negedge aclk);
			ta = s_axi_arvalid && s_axi_arready === 1'b1;
			tr = s_axi_rvalid === 1'b1;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		chk(tr, "read hang");
	endtask : axi_rd
	// Expected word: saturate, then offset reflected code when asked
	function automatic logic [11:0] code(input int v, input bit g);
		logic [11:0] t;
		t = v > 2047 ? 12'h7FF : (v < -2048 ? 12'h800 : v[11:0]);
		return g ? (t ^ 12'h800) ^ ((t ^ 12'h800) >> 1) : t;
	endfunction : code
	task t_lock;
		sfall(40);
		chk(duty_equalizer_locked === 1'b0, "locked early");
		sfall(80);
		chk(duty_equalizer_locked === 1'b1, "not locked");
	endtask : t_lock
	task t_duty;
		int n;
		for (int k = 0; k < 2; k++) begin
			hi = k ? 240 : 80;
			sfall(3);
			n = 0;
			while (output_valid_strobe === 1'b0 && n < 20) begin
				@(negedge aclk);
				n++;
			end
			chk(n == 320 / 40 / 2, "strobe low time");
		end
		hi = 160;
	endtask : t_duty
	task t_code;
		int va [7] = '{0, 1, -1, 2047, -2048, 3000, -3000};
		int nb;
		for (int g = 0; g < 2; g++) begin
			for (int i = 0; i < 7; i++) begin
				nb = -va[i];
				@(posedge aclk);
				code_format_select <= g[0];
				analog_in_a <= va[i][13:0];
				analog_in_b <= nb[13:0];
				sfall(12);
				repeat (6) @(negedge aclk);
				chk(cap_a === code(va[i], g[0]), "word a");
				chk(cap_b === code(nb, g[0]), "word b");
				chk(cap_or === {nb > 2047 || nb < -2048, va[i] > 2047 || va[i] < -2048},
					"flags");
			end
		end
	endtask : t_code
	task t_lat;
		@(posedge aclk);
		code_format_select <= 1'b0;
		analog_in_a <= 14'h0005;
		sfall(12);
		@(posedge aclk);
		analog_in_a <= 14'h0BB8;
		sfall(8);
		chk(channel_a_bus === 12'h005 && over_range_flag_a === 1'b0, "early word");
		sfall(1);
		chk(channel_a_bus === 12'h7FF && over_range_flag_a === 1'b1, "late word");
	endtask : t_lat
	task t_rate;
		logic [1:0] r;
		logic [31:0] s0, s1;
		for (int k = 0; k < 4; k++) begin
			@(posedge aclk);
			quarter_rate_select <= k == 2;
			half_rate_select <= k == 1;
			clock_type_select <= k == 3;
			sfall(4);
			axi_rd(4'hC, s0, r);
			sfall(16);
			axi_rd(4'hC, s1, r);
			chk(s1 - s0 === (k == 1 ? 32'h8 : (k == 2 ? 32'h4 : 32'h10)), "rate");
			axi_rd(4'h4, s0, r);
			chk(s0[3:2] === {k == 2, k == 1} && r === 2'h0, "rate status");
		end
	endtask : t_rate
	task t_pd;
		logic [1:0] r;
		logic [31:0] d;
		@(posedge aclk);
		power_down_pin <= 1'b1;
		repeat (5) @(negedge aclk);
		chk(oes === 5'h00 && clock_in_hiz === 1'b1, "pd floats");
		axi_rd(4'h4, d, r);
		chk(d[1] === 1'b1 && r === 2'h0, "pd status");
		@(posedge aclk);
		power_down_pin <= 1'b0;
		repeat (5) @(negedge aclk);
		chk(oes === 5'h1F && clock_in_hiz === 1'b0, "pd resume");
		axi_wr(4'h0, 32'h1, r);
		repeat (4) @(negedge aclk);
		chk(r === 2'h0 && clock_in_hiz === 1'b1 && oes === 5'h00, "soft pd");
		axi_rd(4'h0, d, r);
		chk(d[1:0] === 2'h1 && duty_equalizer_locked === 1'b1, "ctrl readback");
		axi_wr(4'h0, 32'h2, r);
		axi_rd(4'h2, d, r);
		chk(r === 2'h0 && d === 32'h0, "low address bits ignored");
		chk(duty_equalizer_locked === 1'b0, "relock ignored");
	endtask : t_pd
	// Main sequence
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		t_lock;
		t_duty;
		t_code;
		t_lat;
		t_rate;
		t_pd;
		report_and_stop;
	end
	// Watchdog
	initial begin
		#1000000;
		bad_count++;
		report_and_stop;
	end
endmodule : dacc_tb_top
